// ==== hdl/ush_hw_attr.sv ====
// builds the appended attribute bits for one transaction
`default_nettype none
`include "ush_params.svh"

module ush_hw_attr
   import ush_pkg::*;
(
   input  wire ush_req_s  req,
   input  wire ush_ctrl_s ctrl,
   output ush_ext_s       ext
);

   logic [`USH_ATTR_WIDTH-1:0] s1_ok;
   logic [`USH_ATTR_WIDTH-1:0] s2_ok;

   // a bit counts as permitted only while its stage translates
   assign s2_ok = ctrl.s2_perm & {`USH_ATTR_WIDTH{req.s2_en}};
   assign s1_ok = ctrl.s1_perm & {`USH_ATTR_WIDTH{req.s1_en}};

   always_comb begin
      ext                    = '0;
      ext.outer_cacheable    = req.outer_cacheable;
      ext.context_attr_field = req.ctx_attr;
      // stage 2 owns a bit whenever it may use it, so stage 1 yields
      ext.stage2_hw_attr     = req.s2_desc_hi & s2_ok;
      ext.stage1_hw_attr     = req.s1_desc_hi & s1_ok & ~s2_ok;
   end

endmodule // ush_hw_attr

`default_nettype wire

// ==== hdl/ush_params.svh ====
// constants for the user sideband hardware attribute block
`ifndef USH_PARAMS_SVH
`define USH_PARAMS_SVH

// configured low user width carried through unchanged
`define USH_CFG_USER_WIDTH   8
// number of appended attribute bits
`define USH_EXT_WIDTH        13
// field positions inside the appended bits, relative to the configured width
`define USH_EXT_S1_LSB       0
`define USH_EXT_S2_LSB       4
`define USH_EXT_CTX_LSB      8
`define USH_EXT_OC_BIT       12
// width of each hardware attribute field
`define USH_ATTR_WIDTH       4

// register byte offsets
`define USH_OFS_CTRL         12'h000
`define USH_OFS_LAST         12'h004
`define USH_OFS_COUNT        12'h008
// control field positions
`define USH_CTRL_S1_LSB      0
`define USH_CTRL_S2_LSB      4
// last-attribute field positions
`define USH_LAST_AR_LSB      0
`define USH_LAST_AW_LSB      16
// count field positions
`define USH_COUNT_AR_LSB     0
`define USH_COUNT_AW_LSB     16
`define USH_COUNT_WIDTH      16
// reset values
`define USH_CTRL_RESET       8'h00

`endif

// ==== hdl/ush_pkg.sv ====
// types shared by the user sideband hardware attribute block
`default_nettype none
`include "ush_params.svh"

package ush_pkg;

   localparam int USH_W = `USH_CFG_USER_WIDTH;
   localparam int USH_X = `USH_EXT_WIDTH;

   // one translated transaction arriving from upstream with its response fields
   typedef struct packed {
      logic [USH_W-1:0]               user;
      logic [`USH_ATTR_WIDTH-1:0]     ctx_attr;
      logic [`USH_ATTR_WIDTH-1:0]     s1_desc_hi;
      logic [`USH_ATTR_WIDTH-1:0]     s2_desc_hi;
      logic                           s1_en;
      logic                           s2_en;
      logic                           outer_cacheable;
   } ush_req_s;

   // appended sideband bits, msb first as they sit on the bus
   typedef struct packed {
      logic                           outer_cacheable;
      logic [`USH_ATTR_WIDTH-1:0]     context_attr_field;
      logic [`USH_ATTR_WIDTH-1:0]     stage2_hw_attr;
      logic [`USH_ATTR_WIDTH-1:0]     stage1_hw_attr;
   } ush_ext_s;

   // full downstream sideband word
   typedef struct packed {
      ush_ext_s                       ext;
      logic [USH_W-1:0]               user;
   } ush_user_s;

   // one output register slice
   typedef struct packed {
      logic                           vld;
      ush_user_s                      data;
   } ush_slot_s;

   // software permission masks
   typedef struct packed {
      logic [`USH_ATTR_WIDTH-1:0]     s2_perm;
      logic [`USH_ATTR_WIDTH-1:0]     s1_perm;
   } ush_ctrl_s;

   // whole state of the top module
   typedef struct packed {
      ush_slot_s                      ar;
      ush_slot_s                      aw;
      ush_ctrl_s                      ctrl;
      ush_ext_s                       last_ar;
      ush_ext_s                       last_aw;
      logic [`USH_COUNT_WIDTH-1:0]    cnt_ar;
      logic [`USH_COUNT_WIDTH-1:0]    cnt_aw;
      logic [31:0]                    prdata;
      logic                           pslverr;
   } ush_state_s;

endpackage : ush_pkg

`default_nettype wire

// ==== hdl/ush_sideband.sv ====
// user sideband extender: appends hardware attribute bits to read and write user
`default_nettype none
`include "ush_params.svh"

module ush_sideband
   import ush_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // read channel, upstream
   input  wire logic        ar_up_vld,
   output logic             ar_up_rdy,
   input  wire ush_req_s    ar_up,
   // read channel, downstream
   output logic             ar_dn_vld,
   input  wire logic        ar_dn_rdy,
   output ush_user_s        ar_dn_user,
   // write channel, upstream
   input  wire logic        aw_up_vld,
   output logic             aw_up_rdy,
   input  wire ush_req_s    aw_up,
   // write channel, downstream
   output logic             aw_dn_vld,
   input  wire logic        aw_dn_rdy,
   output ush_user_s        aw_dn_user
);

   typedef enum logic [3:0] {
      USH_SEL_NONE  = 4'h1,
      USH_SEL_CTRL  = 4'h2,
      USH_SEL_LAST  = 4'h4,
      USH_SEL_COUNT = 4'h8
   } ush_sel_e;

   ush_state_s state_r;
   ush_state_s state_nxt;
   ush_ext_s   ar_ext;
   ush_ext_s   aw_ext;
   ush_sel_e   rd_sel;
   ush_sel_e   wr_sel;
   logic       apb_setup;
   logic       apb_write;
   logic       ar_take;
   logic       aw_take;
   logic       ar_give;
   logic       aw_give;

   // address decode, shared by the read and write paths
   function automatic ush_sel_e reg_sel(input logic [11:0] addr);
      ush_sel_e s;
      s = USH_SEL_NONE;
      if (addr == `USH_OFS_CTRL) begin
         s = USH_SEL_CTRL;
      end else if (addr == `USH_OFS_LAST) begin
         s = USH_SEL_LAST;
      end else if (addr == `USH_OFS_COUNT) begin
         s = USH_SEL_COUNT;
      end
      return s;
   endfunction

   // one-deep register slice; accepts a new word whenever it is empty or draining
   function automatic ush_slot_s slot_step(input ush_slot_s cur,
                                           input logic      take,
                                           input logic      give,
                                           input ush_user_s word);
      ush_slot_s n;
      n = cur;
      if (take) begin
         n.vld  = 1'b1;
         n.data = word;
      end else if (give) begin
         n.vld  = 1'b0;
      end
      return n;
   endfunction

   // full sideband word: configured bits below, attribute bits above
   function automatic ush_user_s build_user(input ush_req_s req, input ush_ext_s ext);
      ush_user_s u;
      u      = '0;
      u.user = req.user;
      u.ext  = ext;
      return u;
   endfunction

   ush_hw_attr u_ar_attr (
      .req  (ar_up),
      .ctrl (state_r.ctrl),
      .ext  (ar_ext)
   );

   ush_hw_attr u_aw_attr (
      .req  (aw_up),
      .ctrl (state_r.ctrl),
      .ext  (aw_ext)
   );

   // handshakes are combinational so a full slice still streams one word a cycle
   assign ar_up_rdy = !state_r.ar.vld || ar_dn_rdy;
   assign aw_up_rdy = !state_r.aw.vld || aw_dn_rdy;
   assign ar_take   = ar_up_vld && ar_up_rdy;
   assign aw_take   = aw_up_vld && aw_up_rdy;
   assign ar_give   = state_r.ar.vld && ar_dn_rdy;
   assign aw_give   = state_r.aw.vld && aw_dn_rdy;

   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pwrite;
   assign rd_sel    = reg_sel(paddr);
   assign wr_sel    = reg_sel(paddr);

   always_comb begin
      state_nxt = state_r;

      // sideband path, read and write channels alike
      state_nxt.ar = slot_step(state_r.ar, ar_take, ar_give, build_user(ar_up, ar_ext));
      state_nxt.aw = slot_step(state_r.aw, aw_take, aw_give, build_user(aw_up, aw_ext));
      if (ar_take) begin
         state_nxt.last_ar = ar_ext;
      end
      if (aw_take) begin
         state_nxt.last_aw = aw_ext;
      end
      // counters wrap; software takes differences
      if (ar_give) begin
         state_nxt.cnt_ar = state_r.cnt_ar + `USH_COUNT_WIDTH'(1);
      end
      if (aw_give) begin
         state_nxt.cnt_aw = state_r.cnt_aw + `USH_COUNT_WIDTH'(1);
      end

      // read data is captured in the setup cycle so prdata comes from a flop
      if (apb_setup) begin
         state_nxt.prdata  = '0;
         state_nxt.pslverr = 1'b0;
         unique case (rd_sel)
            USH_SEL_CTRL: begin
               state_nxt.prdata[`USH_CTRL_S1_LSB +: `USH_ATTR_WIDTH] = state_r.ctrl.s1_perm;
               state_nxt.prdata[`USH_CTRL_S2_LSB +: `USH_ATTR_WIDTH] = state_r.ctrl.s2_perm;
            end
            USH_SEL_LAST: begin
               state_nxt.prdata[`USH_LAST_AR_LSB +: USH_X] = state_r.last_ar;
               state_nxt.prdata[`USH_LAST_AW_LSB +: USH_X] = state_r.last_aw;
            end
            USH_SEL_COUNT: begin
               state_nxt.prdata[`USH_COUNT_AR_LSB +: `USH_COUNT_WIDTH] = state_r.cnt_ar;
               state_nxt.prdata[`USH_COUNT_AW_LSB +: `USH_COUNT_WIDTH] = state_r.cnt_aw;
            end
            USH_SEL_NONE: begin
               state_nxt.pslverr = 1'b1;
            end
         endcase
      end

      // writes land at the access edge; only byte lane 0 holds control bits
      if (apb_write && wr_sel == USH_SEL_CTRL && pstrb[0]) begin
         state_nxt.ctrl.s1_perm = pwdata[`USH_CTRL_S1_LSB +: `USH_ATTR_WIDTH];
         state_nxt.ctrl.s2_perm = pwdata[`USH_CTRL_S2_LSB +: `USH_ATTR_WIDTH];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r      <= '0;
         state_r.ctrl <= `USH_CTRL_RESET;
      end else begin
         state_r      <= state_nxt;
      end
   end

   assign prdata     = state_r.prdata;
   assign pslverr    = state_r.pslverr && psel && penable;
   // zero-wait slave: every access phase completes in its first cycle
   assign pready     = 1'b1;

   assign ar_dn_vld  = state_r.ar.vld;
   assign aw_dn_vld  = state_r.aw.vld;
   // bit order of the struct places oc, context, stage 2, stage 1 above user
   assign ar_dn_user = state_r.ar.data;
   assign aw_dn_user = state_r.aw.data;

endmodule // ush_sideband

`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the user sideband extender
`default_nettype none
module testbench
   import ush_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, psel, penable, pwrite, ar_up_vld, aw_up_vld, ar_stall, aw_stall;
   logic        pready, pslverr, err, ar_up_rdy, aw_up_rdy, ar_dn_vld, aw_dn_vld, ar_dn_rdy, aw_dn_rdy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [15:0] ar_n, aw_n, k;
   logic [3:0]  ar_hw, aw_hw;
   ush_req_s    ar_up, aw_up;
   ush_user_s   ar_dn_user, aw_dn_user, ar_got, aw_got, e;
   int          miscompares, comparisons;
   ush_sideband dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .ar_up_vld, .ar_up_rdy, .ar_up, .ar_dn_vld, .ar_dn_rdy, .ar_dn_user, .aw_up_vld, .aw_up_rdy, .aw_up,
      .aw_dn_vld, .aw_dn_rdy, .aw_dn_user);
   ush_dn_model ar_m (.clk, .rst_n, .stall(ar_stall), .vld(ar_dn_vld), .user(ar_dn_user), .rdy(ar_dn_rdy),
      .got(ar_got), .n(ar_n), .hw_attr(ar_hw));
   ush_dn_model aw_m (.clk, .rst_n, .stall(aw_stall), .vld(aw_dn_vld), .user(aw_dn_user), .rdy(aw_dn_rdy),
      .got(aw_got), .n(aw_n), .hw_attr(aw_hw));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic end_sim();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ev, input logic [31:0] g);
      comparisons++;
      if (g !== ev) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, ev, g);
      end
   endtask
   task automatic tmo(input int i);
      if (i >= 20) begin
         miscompares++;
         end_sim();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tmo(i);
   endtask
   // expected word from the stage permission masks and the response fields
   function automatic ush_user_s expv(input ush_req_s r, input logic [7:0] c);
      logic [3:0] s2ok;
      logic [3:0] s1ok;
      s2ok = c[7:4] & {4{r.s2_en}};
      s1ok = c[3:0] & {4{r.s1_en}};
      expv = {r.outer_cacheable, r.ctx_attr, r.s2_desc_hi & s2ok, r.s1_desc_hi & s1ok & ~s2ok, r.user};
   endfunction
   task automatic xfer(input ush_req_s r);
      int i;
      @(posedge clk);
      ar_up <= r;
      aw_up <= {~r.user, r[14:0]};
      ar_up_vld <= 1'b1;
      aw_up_vld <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (ar_up_rdy === 1'b1 && aw_up_rdy === 1'b1) break;
      end
      ar_up_vld <= 1'b0;
      aw_up_vld <= 1'b0;
      k = k + 16'h0001;
      tmo(i);
   endtask
   task automatic xcheck(input ush_req_s r, input logic [7:0] c);
      int i;
      logic [3:0] m;
      for (i = 0; i < 20; i++) begin
         if (ar_n === k && aw_n === k) break;
         @(posedge clk);
      end
      tmo(i);
      e = expv(r, c);
      chk("ar_dn_user", 32'(e), 32'(ar_got));
      e.user = ~r.user;
      chk("aw_dn_user", 32'(e), 32'(aw_got));
      // merged view: an enabled stage 2 bit wins, else an enabled stage 1 bit, else zero
      for (int b = 0; b < 4; b++)
         m[b] = (c[4+b] && r.s2_en) ? r.s2_desc_hi[b] : ((c[b] && r.s1_en) ? r.s1_desc_hi[b] : 1'b0);
      chk("ar_hw_attr", 32'(m), 32'(ar_hw));
      chk("aw_hw_attr", 32'(m), 32'(aw_hw));
   endtask
   task automatic t_regs();
      apb(1'b0, 12'h000, 32'h0, 4'hF);
      chk("ctrl_reset", 32'h0, rd);
      apb(1'b1, 12'h000, 32'h0000005A, 4'hF);
      apb(1'b1, 12'h000, 32'h000000FF, 4'h0);
      apb(1'b0, 12'h000, 32'h0, 4'hF);
      chk("ctrl", 32'h0000005A, rd);
      apb(1'b0, 12'hFFC, 32'h0, 4'hF);
      chk("pslverr", 32'h1, {31'h0, err});
      // status register ignores writes and reports no error for them
      apb(1'b1, 12'h004, 32'hFFFFFFFF, 4'hF);
      apb(1'b0, 12'h004, 32'h0, 4'hF);
      chk("last_ro", 32'h0, rd);
      $display("test regs done");
   endtask
   task automatic t_attr();
      logic [7:0] c [4] = '{8'h0F, 8'hFF, 8'h3C, 8'hFF};
      ush_req_s   r [4] = '{{8'hA5, 4'h9, 4'hF, 4'hF, 3'h3}, {8'h3C, 4'h6, 4'hF, 4'hA, 3'h6},
                            {8'h00, 4'hF, 4'hE, 4'h7, 3'h7}, {8'hFF, 4'h0, 4'h5, 4'hF, 3'h4}};
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 12'h000, {24'h0, c[i]}, 4'hF);
         xfer(r[i]);
         xcheck(r[i], c[i]);
         e = expv(r[i], c[i]);
         apb(1'b0, 12'h004, 32'h0, 4'hF);
         chk("last", {3'h0, e.ext, 3'h0, e.ext}, rd);
      end
      $display("test attr done");
   endtask
   task automatic t_stall();
      ush_req_s r;
      r = {8'h81, 4'h3, 4'hC, 4'h5, 3'h7};
      ar_stall <= 1'b1;
      aw_stall <= 1'b1;
      xfer(r);
      @(posedge clk);
      // held word must block the next one while the far side stalls
      chk("ar_up_rdy", 32'h0, {31'h0, ar_up_rdy});
      ar_stall <= 1'b0;
      aw_stall <= 1'b0;
      xcheck(r, 8'hFF);
      apb(1'b0, 12'h008, 32'h0, 4'hF);
      chk("count", {k, k}, rd);
      $display("test stall done");
   endtask
   initial begin
      {psel, penable, pwrite, ar_up_vld, aw_up_vld, ar_stall, aw_stall, rst_n} = '0;
      {paddr, pwdata, pstrb, ar_up, aw_up} = '0;
      k = '0;
      miscompares = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      // in reset: no word offered downstream, upstream ready, bus idle without error
      chk("reset_outs", 32'h0000000E, {26'h0, ar_dn_vld, aw_dn_vld, ar_up_rdy, aw_up_rdy, pready, pslverr});
      rst_n <= 1'b1;
      t_regs();
      t_attr();
      t_stall();
      end_sim();
   end
endmodule // testbench
`default_nettype wire

// ==== test/ush_dn_model.sv ====
// downstream interconnect model: accepts translated words and can stall
`default_nettype none
module ush_dn_model
   import ush_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       stall,
   input wire logic       vld,
   input wire ush_user_s  user,
   output logic           rdy,
   output ush_user_s      got,
   output logic [15:0]    n,
   output logic [3:0]     hw_attr
);
   timeunit 1ns;
   timeprecision 1ps;
   assign rdy = !stall;
   // the merged view ORs both stages; the whole word stays visible on got
   assign hw_attr = got.ext.stage1_hw_attr | got.ext.stage2_hw_attr;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         got <= '0;
         n <= '0;
      end else if (vld && rdy) begin
         got <= user;
         n <= n + 16'h0001;
      end
   end
endmodule // ush_dn_model
`default_nettype wire

// ==== test/ush_sideband_properties.sv ====
// concurrent checks on the user sideband extender ports
`default_nettype none
module ush_props
   import ush_pkg::*;
(
   input wire logic      clk,
   input wire logic      rst_n,
   input wire logic      ar_up_vld,
   input wire logic      ar_up_rdy,
   input wire ush_req_s  ar_up,
   input wire logic      ar_dn_vld,
   input wire logic      ar_dn_rdy,
   input wire ush_user_s ar_dn_user,
   input wire logic      aw_up_vld,
   input wire logic      aw_up_rdy,
   input wire ush_req_s  aw_up,
   input wire ush_user_s aw_dn_user
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic ar_tk = ar_up_vld && ar_up_rdy;
   wire logic aw_tk = aw_up_vld && aw_up_rdy;
   ar_user_a: assert property (ar_tk |=> ar_dn_vld && ar_dn_user.user == $past(ar_up.user))
      else $error("read low user bits changed");
   ar_oc_a: assert property (ar_tk |=> ar_dn_user.ext.outer_cacheable == $past(ar_up.outer_cacheable))
      else $error("read outer cacheable bit wrong");
   ar_ctx_a: assert property (ar_tk |=> ar_dn_user.ext.context_attr_field == $past(ar_up.ctx_attr))
      else $error("read context bits wrong");
   ar_s2_off_a: assert property (ar_tk && !ar_up.s2_en |=> ar_dn_user.ext.stage2_hw_attr == 4'h0)
      else $error("stage 2 bits set while stage 2 off");
   ar_s1_off_a: assert property (ar_tk && !ar_up.s1_en |=> ar_dn_user.ext.stage1_hw_attr == 4'h0)
      else $error("stage 1 bits set while stage 1 off");
   ar_excl_a: assert property (ar_tk |=> (ar_dn_user.ext.stage1_hw_attr & ar_dn_user.ext.stage2_hw_attr) == 4'h0)
      else $error("stage 1 and stage 2 bits overlap");
   ar_hold_a: assert property (ar_dn_vld && !ar_dn_rdy |=> ar_dn_vld && $stable(ar_dn_user))
      else $error("read word dropped while stalled");
   aw_ctx_a: assert property (aw_tk |=> aw_dn_user.ext.context_attr_field == $past(aw_up.ctx_attr))
      else $error("write context bits wrong");
   aw_s2_sub_a: assert property (aw_tk |=> (aw_dn_user.ext.stage2_hw_attr & ~$past(aw_up.s2_desc_hi)) == 4'h0)
      else $error("write stage 2 bit not from descriptor");
   cover property (ar_tk && ar_up.s1_en && ar_up.s2_en);
   cover property (ar_dn_vld && !ar_dn_rdy ##1 ar_dn_vld);
   cover property (aw_tk && !aw_up.s2_en);
endmodule // ush_props
bind ush_sideband ush_props u_props (.clk, .rst_n, .ar_up_vld, .ar_up_rdy, .ar_up, .ar_dn_vld, .ar_dn_rdy,
   .ar_dn_user, .aw_up_vld, .aw_up_rdy, .aw_up, .aw_dn_user);
`default_nettype wire
